// File: hdl/rxpbc_params.svh
// Offsets, field positions and reset values of the port slice
`ifndef RXPBC_PARAMS_SVH
`define RXPBC_PARAMS_SVH

// ----------------------------------------
// Geometry
// ----------------------------------------
`define RXPBC_NUM_PORTS 4

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RXPBC_OFS_PORT_SEL 8'h4C
`define RXPBC_OFS_TALLY 8'h57
`define RXPBC_OFS_CFG 8'h58
`define RXPBC_OFS_CTL 8'h59

// ----------------------------------------
// Back-channel config fields
// ----------------------------------------
`define RXPBC_CFG_PASS_ALL 7
`define RXPBC_CFG_PASS_MATCH 6
`define RXPBC_CFG_AUTO_ACK 5
`define RXPBC_CFG_PERSIST 4
`define RXPBC_CFG_CRC_GEN 3
`define RXPBC_CFG_RATE_HI 2
`define RXPBC_CFG_RATE_LO 0

// ----------------------------------------
// Forward-path control fields
// ----------------------------------------
`define RXPBC_CTL_KEEP_LOCAL 7
`define RXPBC_CTL_GPIO_HI 1
`define RXPBC_CTL_GPIO_LO 0

// ----------------------------------------
// Reset values and tally saturation point
// ----------------------------------------
`define RXPBC_CFG_RST 8'h18
`define RXPBC_CTL_RST 8'h00
`define RXPBC_TALLY_RST 8'h00
`define RXPBC_SEL_RST 8'h01
`define RXPBC_TALLY_MAX 8'hFF

`endif

// File: hdl/rxpbc_pkg.sv
// Types shared by the port slice modules
package rxpbc_pkg;

  // Port index
  typedef logic [1:0] rxpbc_port_t;

  // Register byte
  typedef logic [7:0] rxpbc_byte_t;

  // Back-channel rate codes; the rest are reserved
  typedef enum logic [2:0] {
    RXPBC_RATE_2M5 = 3'h0,
    RXPBC_RATE_10M = 3'h2,
    RXPBC_RATE_50M = 3'h6
  } rxpbc_rate_t;

endpackage

// File: hdl/rxpbc_tally.sv
// Saturating self-test error tally for one receive port
`timescale 1ns/10ps
`include "rxpbc_params.svh"

module rxpbc_tally (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Self-test events
  input  wire logic             err_pulse,
  input  wire logic             start_pulse,
  // Count
  output      rxpbc_pkg::rxpbc_byte_t count_q
);
  import rxpbc_pkg::*;

  // Saturation point reached
  wire at_max;
  assign at_max = (count_q == `RXPBC_TALLY_MAX);

  // Start clears, errors count up and stop at the top
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_q <= `RXPBC_TALLY_RST;
    end else if (start_pulse) begin
      count_q <= `RXPBC_TALLY_RST;
    end else if (err_pulse && !at_max) begin
      count_q <= count_q + 8'h01;
    end
  end

endmodule

// File: hdl/rxpbc_port_regs.sv
// Back-channel and forward-path settings of one receive port
`timescale 1ns/10ps
`include "rxpbc_params.svh"

module rxpbc_port_regs (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Strap capture
  input  wire logic             strap_load,
  input  wire logic [2:0]       strap_rate,
  // Write strobes
  input  wire logic             loc_we_cfg,
  input  wire logic             loc_we_ctl,
  input  wire logic             rem_we_cfg,
  input  wire logic             rem_we_ctl,
  input  wire logic [7:0]       wdata,
  // Remote load of forward-path settings
  input  wire logic             fc_load,
  input  wire logic [1:0]       fc_gpio,
  // Register contents
  output      logic [7:0]       cfg_q,
  output      logic [7:0]       ctl_q,
  output      logic             bc_en_q
);
  import rxpbc_pkg::*;

  // Pending remote rate change
  logic       pend_q;
  logic [2:0] pend_rate_q;
  logic [7:0] cfg_d;
  logic [7:0] ctl_d;
  logic       pend_d;

  // Remote write changes the rate code
  wire rem_rate_chg;
  assign rem_rate_chg = rem_we_cfg && !loc_we_cfg &&
    (wdata[2:0] != cfg_q[2:0]);

  // Config next value
  always_comb begin
    cfg_d  = cfg_q;
    pend_d = 1'b0;
    if (loc_we_cfg) begin
      cfg_d = wdata;
    end else if (rem_we_cfg) begin
      cfg_d = {wdata[7:5], cfg_q[4], wdata[3:0]};
      if (rem_rate_chg) begin
        cfg_d[2:0] = cfg_q[2:0];
        cfg_d[`RXPBC_CFG_AUTO_ACK] = 1'b1;
        pend_d = 1'b1;
      end
    end else if (pend_q) begin
      cfg_d[2:0] = pend_rate_q;
    end else if (strap_load) begin
      cfg_d[2:0] = strap_rate;
    end
  end

  // Forward-path next value
  always_comb begin
    ctl_d = ctl_q;
    if (loc_we_ctl || rem_we_ctl) begin
      ctl_d[`RXPBC_CTL_KEEP_LOCAL] = wdata[7];
      if (wdata[7]) begin
        ctl_d[1:0] = wdata[1:0];
      end
    end else if (fc_load && !ctl_q[`RXPBC_CTL_KEEP_LOCAL]) begin
      ctl_d[1:0] = fc_gpio;
    end
    ctl_d[6:2] = 5'h00;
  end

  // Register update
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_q       <= `RXPBC_CFG_RST;
      ctl_q       <= `RXPBC_CTL_RST;
      pend_q      <= 1'b0;
      pend_rate_q <= 3'h0;
      bc_en_q     <= 1'b1;
    end else begin
      cfg_q       <= cfg_d;
      ctl_q       <= ctl_d;
      pend_q      <= pend_d;
      if (pend_d) begin
        pend_rate_q <= wdata[2:0];
      end
      bc_en_q <= cfg_d[4] | cfg_d[7] | cfg_d[6];
    end
  end

endmodule

// File: hdl/rxpbc_top.sv
// Per-port back-channel and forward-path register slice, four ports
`timescale 1ns/10ps
`include "rxpbc_params.svh"

module rxpbc_top (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Rate strap, sampled once after reset
  input  wire logic [2:0]        strap_rate,
  // Local host register port
  input  wire logic              loc_wr,
  input  wire logic              loc_rd,
  input  wire logic [7:0]        loc_addr,
  input  wire logic [7:0]        loc_wdata,
  output      logic [7:0]        loc_rdata,
  output      logic              loc_rvalid,
  // Remote control-channel writes
  input  wire logic              rem_wr,
  input  wire rxpbc_pkg::rxpbc_port_t rem_port,
  input  wire logic [7:0]        rem_addr,
  input  wire logic [7:0]        rem_wdata,
  // Forward-channel settings load, per port
  input  wire logic [3:0]        fc_load,
  input  wire logic [7:0]        fc_gpio,
  // Self-test events, per port
  input  wire logic [3:0]        st_err,
  input  wire logic [3:0]        st_start,
  // Back-channel controls, per port
  output      logic [3:0]        pass_all,
  output      logic [3:0]        pass_match,
  output      logic [3:0]        auto_ack,
  output      logic [3:0]        bc_enable,
  output      logic [3:0]        return_channel_check_generation,
  output      logic [11:0]       return_channel_rate_code,
  // Forward-path controls, per port
  output      logic [3:0]        keep_local_path_settings,
  output      logic [7:0]        downstream_gpio_count
);
  import rxpbc_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------

  // Address compare, shared by both write paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] k);
    hit = (a == k);
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------

  // Port select: low nibble write mask, bits 5:4 read port
  logic [7:0] sel_q;
  // Strap capture done
  logic       strap_done_q;
  // Read data next value
  logic [7:0] rdata_d;

  // Per-port register contents
  logic [7:0] cfg   [4];
  logic [7:0] ctl   [4];
  logic [7:0] tally [4];
  logic [3:0] bc_en;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------

  // Local decode
  wire l_sel   = hit(loc_addr, `RXPBC_OFS_PORT_SEL);
  wire l_tally = hit(loc_addr, `RXPBC_OFS_TALLY);
  wire l_cfg   = hit(loc_addr, `RXPBC_OFS_CFG);
  wire l_ctl   = hit(loc_addr, `RXPBC_OFS_CTL);

  // Remote decode
  wire r_cfg   = rem_wr && hit(rem_addr, `RXPBC_OFS_CFG);
  wire r_ctl   = rem_wr && hit(rem_addr, `RXPBC_OFS_CTL);

  // Read port index
  wire [1:0] rd_port = sel_q[5:4];

  // Strap is taken on the first edge after release
  wire strap_load = !strap_done_q;

  // ----------------------------------------
  // Port select and strap capture
  // ----------------------------------------

  // Port select write, strap flag
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_q        <= `RXPBC_SEL_RST;
      strap_done_q <= 1'b0;
    end else begin
      strap_done_q <= 1'b1;
      if (loc_wr && l_sel) begin
        sel_q <= {2'b00, loc_wdata[5:0]};
      end
    end
  end

  // ----------------------------------------
  // Per-port slices
  // ----------------------------------------

  for (genvar p = 0; p < `RXPBC_NUM_PORTS; p++) begin : g_port

    // Local writes reach every port named in the mask
    wire wmask = sel_q[p];
    wire lwc   = loc_wr && l_cfg && wmask;
    wire lwt   = loc_wr && l_ctl && wmask;

    // Remote writes reach only the port they came in on
    wire rsel  = (rem_port == 2'(p));
    wire rwc   = r_cfg && rsel;
    wire rwt   = r_ctl && rsel;

    // Settings storage
    rxpbc_port_regs u_regs (
      .clk        (clk),
      .rst        (rst),
      .strap_load (strap_load),
      .strap_rate (strap_rate),
      .loc_we_cfg (lwc),
      .loc_we_ctl (lwt),
      .rem_we_cfg (rwc && !lwc),
      .rem_we_ctl (rwt && !lwt),
      .wdata      (lwc || lwt ? loc_wdata : rem_wdata),
      .fc_load    (fc_load[p]),
      .fc_gpio    (fc_gpio[2*p +: 2]),
      .cfg_q      (cfg[p]),
      .ctl_q      (ctl[p]),
      .bc_en_q    (bc_en[p])
    );

    // Self-test tally
    rxpbc_tally u_tally (
      .clk         (clk),
      .rst         (rst),
      .err_pulse   (st_err[p]),
      .start_pulse (st_start[p]),
      .count_q     (tally[p])
    );

    // Outputs straight from the slice flops
    assign pass_all[p]   = cfg[p][`RXPBC_CFG_PASS_ALL];
    assign pass_match[p] = cfg[p][`RXPBC_CFG_PASS_MATCH];
    assign auto_ack[p]   = cfg[p][`RXPBC_CFG_AUTO_ACK];
    assign bc_enable[p]  = bc_en[p];
    assign return_channel_check_generation[p] =
      cfg[p][`RXPBC_CFG_CRC_GEN];
    assign return_channel_rate_code[3*p +: 3] =
      cfg[p][`RXPBC_CFG_RATE_HI:`RXPBC_CFG_RATE_LO];
    assign keep_local_path_settings[p] =
      ctl[p][`RXPBC_CTL_KEEP_LOCAL];
    assign downstream_gpio_count[2*p +: 2] =
      ctl[p][`RXPBC_CTL_GPIO_HI:`RXPBC_CTL_GPIO_LO];
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------

  // Read mux for the selected port
  always_comb begin
    rdata_d = 8'h00;
    if (l_sel) begin
      rdata_d = sel_q;
    end else if (l_tally) begin
      rdata_d = tally[rd_port];
    end else if (l_cfg) begin
      rdata_d = cfg[rd_port];
    end else if (l_ctl) begin
      rdata_d = ctl[rd_port];
    end
  end

  // Read answer one cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      loc_rdata  <= 8'h00;
      loc_rvalid <= 1'b0;
    end else begin
      loc_rvalid <= loc_rd;
      if (loc_rd) begin
        loc_rdata <= rdata_d;
      end
    end
  end

endmodule

// File: verification/rxpbc_monitor.sv
// Concurrent checks on the port slice ports
`timescale 1ns/10ps
module rxpbc_monitor (
  // Watched ports
  input wire logic                   clk,
  input wire logic                   rst,
  input wire logic                   loc_wr,
  input wire logic                   loc_rd,
  input wire logic [7:0]             loc_addr,
  input wire logic [7:0]             loc_rdata,
  input wire logic                   loc_rvalid,
  input wire logic                   rem_wr,
  input wire rxpbc_pkg::rxpbc_port_t rem_port,
  input wire logic [7:0]             rem_addr,
  input wire logic [7:0]             rem_wdata,
  input wire logic [3:0]             fc_load,
  input wire logic [7:0]             fc_gpio,
  input wire logic [3:0]             pass_all,
  input wire logic [3:0]             pass_match,
  input wire logic [3:0]             auto_ack,
  input wire logic [3:0]             bc_enable,
  input wire logic [3:0]             return_channel_check_generation,
  input wire logic [11:0]            return_channel_rate_code,
  input wire logic [3:0]             keep_local_path_settings,
  input wire logic [7:0]             downstream_gpio_count
);
  import rxpbc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Remote config write to port 0 with no local write beside it
  wire       rw0    = rem_wr && rem_port == 2'h0 && rem_addr == 8'h58 && !loc_wr;
  // Forward load on port 0 with no competing write
  wire       fl0    = fc_load[0] && !loc_wr && !rem_wr;
  wire [2:0] rate0  = return_channel_rate_code[2:0];
  wire       mapped = loc_addr inside {8'h4C, 8'h57, 8'h58, 8'h59};
  wire       keep0  = keep_local_path_settings[0];
  a_rvalid_pulse: assert property (loc_rd |=> loc_rvalid)
    else $error("read answer missing");
  a_rvalid_idle: assert property (!loc_rd |=> !loc_rvalid)
    else $error("read answer without read");
  a_unmapped_zero: assert property (loc_rd && !mapped |=> loc_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_ctl_reserved: assert property (loc_rd && loc_addr == 8'h59 |=> loc_rdata[6:2] == 5'h00)
    else $error("reserved bits not zero");
  a_bc_needs: assert property (((pass_all | pass_match) & ~bc_enable) == 4'h0)
    else $error("back channel off with pass bit");
  a_persist_kept: assert property (rw0 && bc_enable[0] && !pass_all[0] && !pass_match[0]
    |=> bc_enable[0])
    else $error("persistence changed remotely");
  a_rate_forced: assert property (rw0 && rem_wdata[2:0] != rate0
    |=> auto_ack[0] ##1 rate0 == $past(rem_wdata[2:0], 2))
    else $error("rate change without auto ack");
  a_remote_cfg: assert property (rw0 && rem_wdata[2:0] == rate0 |=> pass_all[0] ==
    $past(rem_wdata[7]) && auto_ack[0] == $past(rem_wdata[5])
    && return_channel_check_generation[0] == $past(rem_wdata[3]))
    else $error("remote config not applied");
  a_gpio_load: assert property (fl0 && !keep0 |=> downstream_gpio_count[1:0]
    == $past(fc_gpio[1:0]))
    else $error("forward load lost");
  a_keep_blocks: assert property (fl0 && keep0 |=> $stable(downstream_gpio_count[1:0]))
    else $error("forward load not blocked");
  c_rate: cover property (rw0 && rem_wdata[2:0] != rate0);
  c_load: cover property (fl0 && !keep0);
  c_unmapped: cover property (loc_rd && !mapped);
endmodule
bind rxpbc_top rxpbc_monitor u_mon (.*);

// File: verification/rxpbc_ser_model.sv
// Remote serializer stand-in: control writes and forward loads
`timescale 1ns/10ps
module rxpbc_ser_model (
  // Clock
  input  wire logic       clk,
  // Control channel and forward loads
  output rxpbc_pkg::rxpbc_port_t rem_port,
  output      logic       rem_wr,
  output      logic [7:0] rem_addr,
  output      logic [7:0] rem_wdata,
  output      logic [3:0] fc_load,
  output      logic [7:0] fc_gpio
);
  import rxpbc_pkg::*;
  initial {rem_wr, rem_port, rem_addr, rem_wdata, fc_load, fc_gpio} = '0;
  // One write; lines inverted once released
  task automatic send(input logic [1:0] p, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    {rem_wr, rem_port, rem_addr, rem_wdata} = {1'b1, p, a, d};
    @(posedge clk) #1;
    {rem_wr, rem_addr, rem_wdata} = {1'b0, ~a, ~d};
    @(posedge clk); // Quiet cycle rides over errors after a rate change
  endtask
  // One forward-channel load pulse
  task automatic load(input logic [1:0] p, input logic [1:0] g);
    @(posedge clk) #1;
    fc_load[p] = 1'b1;
    fc_gpio[2*p+:2] = g;
    @(posedge clk) #1;
    fc_load = 4'h0;
    fc_gpio = ~fc_gpio;
  endtask
endmodule

// File: verification/tb_rxpbc_top.sv
// Self-checking bench for the port slice
`timescale 1ns/10ps
module tb_rxpbc_top;
  import rxpbc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, loc_wr = 1'b0, loc_rd = 1'b0, loc_rvalid, rem_wr;
  logic [2:0] strap_rate = 3'h6;
  logic [7:0] loc_addr = 8'h00, loc_wdata = 8'h00, loc_rdata, rem_addr, rem_wdata, fc_gpio;
  logic [3:0] st_err = 4'h0, st_start = 4'h0, fc_load, pass_all, pass_match, auto_ack;
  logic [3:0] bc_enable, return_channel_check_generation, keep_local_path_settings;
  logic [11:0] return_channel_rate_code;
  logic [7:0] downstream_gpio_count, sel_m, cfg_m [4], ctl_m [4], tal_m [4];
  logic [2:0] codes [4] = '{RXPBC_RATE_2M5, RXPBC_RATE_10M, RXPBC_RATE_50M, 3'h5};
  rxpbc_port_t rem_port;
  logic [7:0] q [$];
  int num_errors = 0, compares = 0;
  always #5 clk = ~clk;
  rxpbc_ser_model ser (.*);
  rxpbc_top dut (.*);
  // Verdict and end of run
  task automatic stop_test;
    // A read answer still owed counts as a mismatch
    if (q.size() != 0) num_errors++;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Read results against the oldest note
  always @(negedge clk) if (loc_rvalid === 1'b1) begin
    if (q.size() == 0) chk("rdata extra", 12'h000, 12'hFFF);
    else chk("rdata", {4'h0, q.pop_front()}, {4'h0, loc_rdata});
  end
  function automatic logic [7:0] expv(input logic [7:0] a);
    case (a)
      8'h4C: return sel_m;
      8'h57: return tal_m[sel_m[5:4]];
      8'h58: return cfg_m[sel_m[5:4]];
      8'h59: return ctl_m[sel_m[5:4]];
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic [7:0] ctlw(input logic [7:0] o, input logic [7:0] d);
    return d[7] ? (d & 8'h83) : {6'h00, o[1:0]};
  endfunction
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    {loc_addr, loc_wdata, loc_wr, loc_rd} = {a, d, w, !w};
    @(posedge clk) #1;
    {loc_wr, loc_rd} = 2'b00;
  endtask
  task automatic rd(input logic [7:0] a);
    q.push_back(expv(a));
    bus(1'b0, a, 8'h00);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
    if (a == 8'h4C) sel_m = d & 8'h3F;
    for (int p = 0; p < 4; p++) begin
      if (sel_m[p] && a == 8'h58) cfg_m[p] = d;
      if (sel_m[p] && a == 8'h59) ctl_m[p] = ctlw(ctl_m[p], d);
    end
  endtask
  task automatic rsend(input logic [1:0] p, input logic [7:0] a, input logic [7:0] d);
    ser.send(p, a, d);
    if (a == 8'h59) ctl_m[p] = ctlw(ctl_m[p], d);
    if (a == 8'h58) cfg_m[p] = {d[7:6], d[5] | (d[2:0] != cfg_m[p][2:0]), cfg_m[p][4], d[3:0]};
  endtask
  task automatic fl(input logic [1:0] p, input logic [1:0] g);
    ser.load(p, g);
    if (!ctl_m[p][7]) ctl_m[p][1:0] = g;
  endtask
  task automatic pulse(input logic [1:0] p, input logic clr, input int n);
    @(posedge clk) #1;
    if (clr) st_start[p] = 1'b1;
    else st_err[p] = 1'b1;
    repeat (n) @(posedge clk);
    #1 {st_start, st_err} = 8'h00;
    tal_m[p] = clr ? 8'h00 : (int'(tal_m[p]) + n > 255) ? 8'hFF : 8'(tal_m[p] + n);
  endtask
  // Every port's control outputs against the models
  task automatic outs(input string n);
    for (int p = 0; p < 4; p++) chk("outs", {1'b0, cfg_m[p][7:5], |{cfg_m[p][7:6], cfg_m[p][4]},
      cfg_m[p][3:0], ctl_m[p][7], ctl_m[p][1:0]}, {1'b0, pass_all[p], pass_match[p],
      auto_ack[p], bc_enable[p], return_channel_check_generation[p],
      return_channel_rate_code[3*p+:3], keep_local_path_settings[p],
      downstream_gpio_count[2*p+:2]});
    $display("test %s done", n);
  endtask
  task automatic do_reset(input logic [2:0] s);
    // Let a read answer still in flight be compared before reset clears it
    @(posedge clk);
    @(posedge clk) #1;
    {strap_rate, rst} = {s, 1'b1};
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    for (int p = 0; p < 4; p++) {cfg_m[p], ctl_m[p], tal_m[p]} = {5'h03, s, 16'h0000};
    sel_m = 8'h01;
    repeat (2) @(posedge clk);
  endtask
  // Hang guard
  initial begin
    #100000;
    num_errors++;
    stop_test();
  end
  initial begin
    void'($urandom(32'h5c12f344));
    do_reset(3'h6);
    rd(8'h4C);
    for (int p = 0; p < 4; p++) begin
      wr(8'h4C, {2'h0, p[1:0], 4'h0});
      foreach (codes[i]) rd(8'h57 + 8'(i));
    end
    outs("reset");
    for (int p = 0; p < 4; p++) begin
      wr(8'h4C, {2'h0, p[1:0], 4'h1 << p});
      wr(8'h58, {5'($urandom()), codes[p]});
      wr(8'h59, 8'hFF);
      wr(8'h57, 8'hAA);
    end
    outs("config");
    pulse(1, 1'b0, 3);
    pulse(2, 1'b0, 300);
    pulse(0, 1'b0, 5);
    pulse(0, 1'b1, 1);
    wr(8'h4C, 8'h01);
    fl(0, 2'h1);
    wr(8'h59, 8'h7F);
    fl(0, 2'h2);
    wr(8'h59, 8'hFD);
    rsend(0, 8'h59, 8'h00);
    outs("path");
    wr(8'h58, 8'h10);
    rsend(0, 8'h58, 8'h08);
    rsend(0, 8'h58, 8'hC6);
    rsend(1, 8'h58, 8'h00);
    rsend(0, 8'h57, 8'h55);
    outs("remote");
    wr(8'h58, 8'h00);
    outs("persist off");
    wr(8'h58, 8'h40);
    outs("match");
    for (int p = 0; p < 4; p++) begin
      wr(8'h4C, {2'h0, p[1:0], 4'h0});
      foreach (codes[i]) rd(8'h57 + 8'(i));
    end
    do_reset(3'h2);
    outs("strap");
    rd(8'h58);
    repeat (3) @(posedge clk);
    stop_test();
  end
endmodule
